// ### src/dcs_defs.vh
// Constants for the converter configuration register bank and its serial slave
`ifndef DCS_DEFS_VH
`define DCS_DEFS_VH
`define DCS_CLK_MHZ 250
`define DCS_ADDR_FIXED 4'hc
`define DCS_ADDR_LOW_DEF 3'h0
`define DCS_CNV_WIDTH 12
`define DCS_CNV_IMPL_BITS 12
`define DCS_REF_UPPER 1
`define DCS_REF_LOWER 0
`define DCS_PD_HI 3
`define DCS_PD_LO 2
`define DCS_GAIN_BIT 4
`define DCS_CFG_BOR 5'h0c
`define DCS_CFG_SHIP 5'h00
`define DCS_CNV_SHIP 12'h000
`define DCS_PD_NORMAL 2'h0
`define DCS_CMD_VOLATILE 3'h2
`define DCS_CMD_ALL 3'h3
`define DCS_CMD_CONFIG 3'h4
`define DCS_NVW_TIME_NS 25000
`define DCS_NVW_CYCLES ((`DCS_NVW_TIME_NS * `DCS_CLK_MHZ) / 1000)
`endif

// ### src/dcs_i2c_regs.v
// Converter configuration and data registers behind a two-wire serial slave
`timescale 1ns/10ps
`include "dcs_defs.vh"
// Function
// - Reference field: upper bit clear selects supply; else lower bit picks pin unbuffered/buffered.
// - Power-down field 00 normal; 01, 10, 11 pick ground loads 1k, 100k, 500k.
// - Any power-down code switches circuits off and disconnects the output amplifier.
// - Gain bit gives one or two; supply reference always forces gain one.
// - Brown-out forces reference 00, power-down 11, gain 0.
// - Power-on loads configuration and data from nonvolatile copy, shipped as zero.
// - Data register is 8, 10 or 12 bits; unimplemented upper bits unused.
// - Interface is slave only; never generates clock, start or stop.
// - Standard, fast and high-speed bit rates up to 3.4 Mbit/s work.
// - Data line sampled on the rising serial clock edge of each received bit and master acknowledge.
// - Data changes during clock high are taken as start or stop.
// - Device never holds the serial clock low.
// - While nonvolatile write busy, every command except a read is ignored.
// - A stop condition resets the serial interface state.
// - Slave address is fixed 1100 followed by a three-bit part code.
module dcs_i2c_regs #(
	parameter [2:0] ADDR_LOW = `DCS_ADDR_LOW_DEF,
	parameter [15:0] NVW_CYCLES = `DCS_NVW_CYCLES
) (
	input wire clk,
	input wire reset_n,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out_r,
	output reg sda_oe_r,
	input wire brown_out,
	input wire factory_blank,
	output reg [1:0] ladder_reference_select_r,
	output reg [1:0] shutdown_load_select_r,
	output reg gain_select_r,
	output reg [11:0] converter_value_r,
	output reg reference_from_pin_r,
	output reg reference_buffered_r,
	output reg gain_two_r,
	output reg amp_connected_r,
	output reg [2:0] ground_load_r,
	output reg nonvolatile_write_idle_r
);
	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_RX = 5'h02;
	localparam [4:0] ST_RACK = 5'h04;
	localparam [4:0] ST_TX = 5'h08;
	localparam [4:0] ST_MACK = 5'h10;

	function [11:0] cnv_mask;
		input [11:0] v;
		begin
			cnv_mask = v & ((12'h001 << `DCS_CNV_IMPL_BITS) - 12'h001);
		end
	endfunction

	// Two-stage synchronisers; stage one feeds only stage two
	reg scl_s1_r, scl_s2_r, scl_d_r;
	reg sda_s1_r, sda_s2_r, sda_d_r;
	reg bor_s1_r, bor_s2_r, blank_s1_r, blank_s2_r;
	reg [4:0] state_r;
	reg [3:0] bitcnt_r;
	reg [1:0] idx_r;
	reg is_addr_r, read_r, mack_ok_r;
	reg [7:0] shreg_r, txbyte_r;
	reg [2:0] cmd_r;
	reg [4:0] cfg_tmp_r, cfg_r, nv_cfg_r;
	reg [7:0] hi_tmp_r;
	reg [11:0] nv_cnv_r;
	reg [15:0] nvw_cnt_r;
	wire scl_rise = scl_s2_r & ~scl_d_r;
	wire scl_fall = ~scl_s2_r & scl_d_r;
	wire start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
	wire stop_det = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
	wire busy = (nvw_cnt_r != 16'h0000);
	wire [7:0] status_byte = {~busy, 2'b10, cfg_r};
	wire [11:0] cnv_new = cnv_mask({hi_tmp_r, shreg_r[7:4]});

	always @(posedge clk) begin
		scl_s1_r <= scl_in;
		scl_s2_r <= scl_s1_r;
		scl_d_r <= scl_s2_r;
		sda_s1_r <= sda_in;
		sda_s2_r <= sda_s1_r;
		sda_d_r <= sda_s2_r;
		bor_s1_r <= brown_out;
		bor_s2_r <= bor_s1_r;
		blank_s1_r <= factory_blank;
		blank_s2_r <= blank_s1_r;
	end

	// Nonvolatile copy survives reset; only a blank strap at reset clears it
	always @(posedge clk) begin
		if (!reset_n) begin
			if (blank_s2_r) begin
				nv_cfg_r <= `DCS_CFG_SHIP;
				nv_cnv_r <= `DCS_CNV_SHIP;
			end
		end else if (state_r == ST_RX && scl_fall && bitcnt_r == 4'h8 && !is_addr_r &&
				!busy && idx_r == 2'h2 && cmd_r == `DCS_CMD_ALL) begin
			nv_cfg_r <= cfg_tmp_r;
			nv_cnv_r <= cnv_new;
		end
	end

	// Derived analog controls, one cycle behind the fields
	always @(posedge clk) begin
		if (!reset_n) begin
			reference_from_pin_r <= 1'b0;
			reference_buffered_r <= 1'b0;
			gain_two_r <= 1'b0;
			amp_connected_r <= 1'b0;
			ground_load_r <= 3'h0;
		end else begin
			reference_from_pin_r <= cfg_r[`DCS_REF_UPPER];
			reference_buffered_r <= cfg_r[`DCS_REF_UPPER] & cfg_r[`DCS_REF_LOWER];
			gain_two_r <= cfg_r[`DCS_REF_UPPER] & cfg_r[`DCS_GAIN_BIT];
			amp_connected_r <= (cfg_r[`DCS_PD_HI:`DCS_PD_LO] == `DCS_PD_NORMAL);
			// One-hot: bit0 1k, bit1 100k, bit2 500k
			ground_load_r <= {cfg_r[3] & cfg_r[2], cfg_r[3] & ~cfg_r[2],
				~cfg_r[3] & cfg_r[2]};
		end
	end

	always @(posedge clk) begin
		ladder_reference_select_r <= cfg_r[1:0];
		shutdown_load_select_r <= cfg_r[3:2];
		gain_select_r <= cfg_r[4];
		nonvolatile_write_idle_r <= ~busy;
	end

	// Serial slave; SCL is input only, so no stretching is possible
	always @(posedge clk) begin
		if (!reset_n) begin
			cfg_r <= nv_cfg_r;
			converter_value_r <= cnv_mask(nv_cnv_r);
			state_r <= ST_IDLE;
			sda_out_r <= 1'b0;
			sda_oe_r <= 1'b0;
			bitcnt_r <= 4'h0;
			idx_r <= 2'h0;
			is_addr_r <= 1'b0;
			read_r <= 1'b0;
			mack_ok_r <= 1'b0;
			shreg_r <= 8'h00;
			txbyte_r <= 8'h00;
			cmd_r <= 3'h0;
			cfg_tmp_r <= 5'h00;
			hi_tmp_r <= 8'h00;
			nvw_cnt_r <= 16'h0000;
		end else if (bor_s2_r) begin
			// Brown-out also holds the interface deaf
			cfg_r <= `DCS_CFG_BOR;
			converter_value_r <= 12'h000;
			state_r <= ST_IDLE;
			sda_oe_r <= 1'b0;
		end else begin
			if (busy)
				nvw_cnt_r <= nvw_cnt_r - 16'h0001;
			if (stop_det) begin
				state_r <= ST_IDLE;
				sda_oe_r <= 1'b0;
			end else if (start_det) begin
				state_r <= ST_RX;
				sda_oe_r <= 1'b0;
				bitcnt_r <= 4'h0;
				idx_r <= 2'h0;
				is_addr_r <= 1'b1;
			end else begin
				case (state_r)
				ST_IDLE: begin
					sda_oe_r <= 1'b0;
				end
				ST_RX: begin
					if (scl_rise) begin
						shreg_r <= {shreg_r[6:0], sda_s2_r};
						bitcnt_r <= bitcnt_r + 4'h1;
					end else if (scl_fall && bitcnt_r == 4'h8) begin
						bitcnt_r <= 4'h0;
						if (is_addr_r) begin
							is_addr_r <= 1'b0;
							read_r <= shreg_r[0];
							if (shreg_r[7:1] == {`DCS_ADDR_FIXED, ADDR_LOW}) begin
								state_r <= ST_RACK;
								sda_oe_r <= 1'b1;
							end else
								state_r <= ST_IDLE;
						end else if (busy || read_r) begin
							state_r <= ST_IDLE;
						end else begin
							state_r <= ST_RACK;
							sda_oe_r <= 1'b1;
							idx_r <= idx_r + 2'h1;
							case (idx_r)
							2'h0: begin
								cmd_r <= shreg_r[7:5];
								cfg_tmp_r <= shreg_r[4:0];
								if (shreg_r[7:5] == `DCS_CMD_CONFIG)
									cfg_r <= shreg_r[4:0];
								else if (shreg_r[7:5] != `DCS_CMD_VOLATILE &&
										shreg_r[7:5] != `DCS_CMD_ALL) begin
									state_r <= ST_IDLE;
									sda_oe_r <= 1'b0;
								end
							end
							2'h1: begin
								hi_tmp_r <= shreg_r;
								if (cmd_r == `DCS_CMD_CONFIG) begin
									state_r <= ST_IDLE;
									sda_oe_r <= 1'b0;
								end
							end
							2'h2: begin
								cfg_r <= cfg_tmp_r;
								converter_value_r <= cnv_new;
								if (cmd_r == `DCS_CMD_ALL)
									nvw_cnt_r <= NVW_CYCLES;
							end
							default: begin
								state_r <= ST_IDLE;
								sda_oe_r <= 1'b0;
							end
							endcase
						end
					end
				end
				ST_RACK: begin
					if (scl_fall) begin
						if (read_r) begin
							state_r <= ST_TX;
							txbyte_r <= status_byte;
							sda_oe_r <= ~status_byte[7];
							bitcnt_r <= 4'h1;
							idx_r <= 2'h1;
						end else begin
							state_r <= ST_RX;
							sda_oe_r <= 1'b0;
						end
					end
				end
				ST_TX: begin
					// Drive changes only after SCL falls, keeping data stable while high
					if (scl_fall) begin
						if (bitcnt_r == 4'h8) begin
							state_r <= ST_MACK;
							sda_oe_r <= 1'b0;
						end else begin
							sda_oe_r <= ~txbyte_r[3'h7 - bitcnt_r[2:0]];
							bitcnt_r <= bitcnt_r + 4'h1;
						end
					end
				end
				ST_MACK: begin
					if (scl_rise)
						mack_ok_r <= ~sda_s2_r;
					else if (scl_fall) begin
						if (mack_ok_r) begin
							state_r <= ST_TX;
							bitcnt_r <= 4'h1;
							idx_r <= (idx_r == 2'h2) ? 2'h0 : idx_r + 2'h1;
							case (idx_r)
							2'h1: begin
								txbyte_r <= converter_value_r[11:4];
								sda_oe_r <= ~converter_value_r[11];
							end
							2'h2: begin
								txbyte_r <= {converter_value_r[3:0], 4'h0};
								sda_oe_r <= ~converter_value_r[3];
							end
							default: begin
								txbyte_r <= status_byte;
								sda_oe_r <= ~status_byte[7];
							end
							endcase
						end else
							state_r <= ST_IDLE;
					end
				end
				default: begin
					state_r <= ST_IDLE;
					sda_oe_r <= 1'b0;
				end
				endcase
			end
		end
	end
	// At 250 MHz a 3.4 Mbit/s bit still spans about 70 samples, ample for the sync delay.
endmodule

// ### verif/dcs_i2c_regs_chk.sv
// Port assertions for the converter register bank
`timescale 1ns/10ps
module dcs_i2c_regs_chk (
	input wire clk,
	input wire reset_n,
	input wire scl_in,
	input wire sda_oe_r,
	input wire brown_out,
	input wire [1:0] ladder_reference_select_r,
	input wire [1:0] shutdown_load_select_r,
	input wire gain_select_r,
	input wire [11:0] converter_value_r,
	input wire reference_from_pin_r,
	input wire reference_buffered_r,
	input wire gain_two_r,
	input wire amp_connected_r,
	input wire [2:0] ground_load_r,
	input wire nonvolatile_write_idle_r
);
	wire [1:0] rs = ladder_reference_select_r;
	wire [1:0] pd = shutdown_load_select_r;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Sync delay of two flops plus two updates (config register, then output register)
	sequence s_brown;
		brown_out [*4];
	endsequence
	sequence s_busy;
		$fell(nonvolatile_write_idle_r);
	endsequence
	// Field outputs and derived controls update on the same edge
	chk_ref_pin: assert property ($past(reset_n) |->
		reference_from_pin_r == rs[1]) else $error("ref pin");
	chk_ref_buf: assert property ($past(reset_n) |->
		reference_buffered_r == (&rs)) else $error("ref buf");
	chk_gain_eff: assert property ($past(reset_n) |->
		gain_two_r == (rs[1] & gain_select_r)) else $error("gain");
	chk_amp_conn: assert property ($past(reset_n) |->
		amp_connected_r == (pd == 2'h0)) else $error("amp");
	chk_load_map: assert property ($past(reset_n) |->
		ground_load_r == {pd == 2'h3, pd == 2'h2, pd == 2'h1}) else $error("load");
	chk_brown_cfg: assert property (s_brown |=>
		{rs, pd, gain_select_r} == 5'h06 && converter_value_r == 12'h000) else $error("bor");
	chk_brown_idle: assert property (s_brown |=> !sda_oe_r) else $error("bor sda");
	chk_sda_low: assert property ($changed(sda_oe_r) |->
		!scl_in && !$past(scl_in, 2)) else $error("sda in high");
	chk_nvw_hold: assert property (s_busy |->
		!nonvolatile_write_idle_r [*8]) else $error("busy short");
endmodule

// ### verif/dcs_i2c_master.sv
// Bus master model driving clock and open-drain data
`timescale 1ns/10ps
module dcs_i2c_master (
	input wire clk,
	input wire sda,
	output reg scl,
	output reg sda_m
);
	int qc = 6;
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	// Steps on the falling edge, clear of the sampling edge
	task q;
		repeat (qc) @(negedge clk);
	endtask
	task bit_io(input logic b, output logic r);
		sda_m = b;
		q;
		scl = 1'b1;
		q;
		r = sda;
		q;
		scl = 1'b0;
		q;
	endtask
	task start;
		sda_m = 1'b1;
		q;
		scl = 1'b1;
		q;
		sda_m = 1'b0;
		q;
		scl = 1'b0;
		q;
	endtask
	task stop;
		sda_m = 1'b0;
		q;
		scl = 1'b1;
		q;
		sda_m = 1'b1;
		q;
	endtask
	task wb(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task rb(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask
endmodule

// ### verif/dcs_i2c_regs_tb_top.sv
// Self-checking bench for the converter register bank
`timescale 1ns/10ps
`include "dcs_defs.vh"
`define CHK(n, e, a) begin \
	total_checks++; \
	if ((a) !== (e)) begin \
		error_cnt++; \
		$display("MISMATCH %s exp %h got %h", n, e, a); \
	end \
end
module dcs_i2c_regs_tb_top;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic brown_out = 1'b0;
	logic factory_blank = 1'b1;
	int error_cnt = 0;
	int total_checks = 0;
	wire scl, sda_m, sda_out_r, sda_oe_r, g, rpin, rbuf, g2, amp, idle;
	wire [1:0] rs, pd;
	wire [11:0] dv;
	wire [2:0] gl;
	// Pull-up: released line reads high
	wire sda = sda_m & (sda_oe_r ? sda_out_r : 1'b1);
	localparam logic [6:0] ADR = {`DCS_ADDR_FIXED, `DCS_ADDR_LOW_DEF};
	dcs_i2c_master m (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));
	dcs_i2c_regs #(.NVW_CYCLES(16'h07d0)) i_dut (.clk(clk), .reset_n(reset_n), .scl_in(scl),
		.sda_in(sda), .sda_out_r(sda_out_r), .sda_oe_r(sda_oe_r), .brown_out(brown_out),
		.factory_blank(factory_blank), .ladder_reference_select_r(rs),
		.shutdown_load_select_r(pd), .gain_select_r(g), .converter_value_r(dv),
		.reference_from_pin_r(rpin), .reference_buffered_r(rbuf), .gain_two_r(g2),
		.amp_connected_r(amp), .ground_load_r(gl), .nonvolatile_write_idle_r(idle));
	initial forever #2 clk = ~clk;
	task wr(input logic [23:0] v, input int n, output logic [3:0] a);
		logic k;
		a = 4'h0;
		m.start;
		m.wb({ADR, 1'b0}, a[3]);
		for (int i = 0; i < n; i++) begin
			m.wb(v[23 - 8 * i -: 8], k);
			a[2 - i] = k;
		end
		m.stop;
	endtask
	task rd(output logic [23:0] v);
		logic k;
		m.start;
		m.wb({ADR, 1'b1}, k);
		for (int i = 0; i < 3; i++)
			m.rb(i == 2, v[23 - 8 * i -: 8]);
		m.stop;
	endtask
	task rst(input logic fb);
		factory_blank = fb;
		reset_n = 1'b0;
		repeat (8) @(negedge clk);
		reset_n = 1'b1;
		// Strap dropped after reset so a later reset keeps the stored copy
		factory_blank = 1'b0;
		repeat (4) @(negedge clk);
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		logic [3:0] a;
		logic [23:0] r;
		logic k;
		int n;
		rst(1'b1);
		`CHK("por", 17'h0, {g, pd, rs, dv})
		m.start;
		m.wb({ADR ^ 7'h01, 1'b0}, k);
		m.stop;
		`CHK("foreign", 1'b0, k)
		m.start;
		m.wb({ADR, 1'b0}, k);
		m.stop;
		`CHK("own", 1'b1, k)
		for (int i = 0; i < 4; i++) begin
			wr({3'h4, 1'b1, i[1:0], i[1:0], 16'h0000}, 1, a);
			`CHK("cfg", {4'hc, 1'b1, i[1:0], i[1:0]}, {a, g, pd, rs})
			`CHK("amp", i == 0, amp)
			`CHK("load", (i == 0) ? 3'h0 : 3'h1 << (i - 1), gl)
			`CHK("buf", i == 3, rbuf)
			`CHK("pin", i > 1, rpin)
			`CHK("g2", i > 1, g2)
		end
		$display("cfg test end");
		wr({3'h2, 5'h13, 12'ha5c, 4'h0}, 3, a);
		`CHK("vol", {4'hf, 12'ha5c}, {a, dv})
		m.qc = 20;
		rd(r);
		m.qc = 6;
		`CHK("read", {3'b110, 5'h13, 12'ha5c, 4'h0}, r)
		brown_out = 1'b1;
		repeat (10) @(negedge clk);
		`CHK("bor", {5'h0c, 12'h000}, {g, pd, rs, dv})
		brown_out = 1'b0;
		$display("data test end");
		wr({3'h3, 5'h08, 12'h3c1, 4'h0}, 3, a);
		`CHK("busy", 1'b0, idle)
		wr({3'h2, 5'h00, 12'h111, 4'h0}, 1, a);
		`CHK("nack", 4'h8, a)
		rd(r);
		`CHK("bread", {3'b010, 5'h08, 12'h3c1, 4'h0}, r)
		for (n = 0; n < 4000 && idle !== 1'b1; n++)
			@(negedge clk);
		if (n == 4000) begin
			error_cnt++;
			stop_test;
		end
		wr({3'h2, 5'h1f, 16'h0000}, 3, a);
		rst(1'b0);
		`CHK("recall", {5'h08, 12'h3c1}, {g, pd, rs, dv})
		$display("nv test end");
		stop_test;
	end
endmodule
bind dcs_i2c_regs dcs_i2c_regs_chk i_chk (.clk, .reset_n, .scl_in, .sda_oe_r, .brown_out,
	.ladder_reference_select_r, .shutdown_load_select_r, .gain_select_r, .converter_value_r,
	.reference_from_pin_r, .reference_buffered_r, .gain_two_r, .amp_connected_r,
	.ground_load_r, .nonvolatile_write_idle_r);
